/* File: hdl/charlieplex_params.svh */
// constants for the charlieplexed led scanner
`ifndef CHARLIEPLEX_PARAMS_SVH
`define CHARLIEPLEX_PARAMS_SVH

`define CP_CLK_HZ              200000000
`define CP_REFRESH_HZ          60
`define CP_MIN_REFRESH_HZ      50
`define CP_BASE_DIV            64
`define CP_REFRESH_BASE_TICKS  (`CP_CLK_HZ / `CP_BASE_DIV / `CP_REFRESH_HZ)
`define CP_STEP_DIV            40
`define CP_BLANK_STEPS         4
`define CP_NUM_PINS            5
`define CP_NUM_LEDS            19
`define CP_NUM_GROUPS          5
`define CP_SLOTS               4
`define CP_LAST_STEP           8'hFF
`define CP_LAST_GROUP          3'h4

`endif

/* File: hdl/charlieplex_pkg.sv */
// types shared by the charlieplexed led scanner
package charlieplex_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_BLANK = 3'b010,
    ST_LIT   = 3'b100
  } scan_state_t;

  typedef logic [7:0] on_time_t;

endpackage

/* File: hdl/event_timer.sv */
// periodic timer counting enabled events, one-cycle tick at each period end
`timescale 1ns/10ps
module event_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  input  wire logic             count_en_in,
  input  wire logic [WIDTH-1:0] period_in,
  output logic                  tick_out
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || clear_in)
    begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end
    else if (count_en_in && (count_q == period_in - 1'b1))
    begin
      count_q  <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      if (count_en_in)
        count_q <= count_q + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule

/* File: hdl/charlieplex_led_scanner.sv */
// charlieplexed scanner: nineteen leds with on-time bytes on five tri-state pins
//
// Operation
// R1 - nineteen leds, five pins, distinct ordered pairs
// R2 - unselected pins stay high impedance
// R3 - only one common-anode group lit
// R4 - light each group in turn, repeat
// R5 - full refresh repeats at sixty hertz
// R6 - refresh never at or below fifty hertz
// R7 - refresh timer clocked by base timer
// R8 - refresh preempts lower service, which resumes
// R9 - only refresh holds top priority
// R10 - one on-time byte per led
// R11 - zero on-time keeps led dark
// R12 - each refresh tick walks whole table
// R13 - status modules rewrite entries on change
// R14 - all pins high impedance between groups
`timescale 1ns/10ps
`include "charlieplex_params.svh"
module charlieplex_led_scanner #(
  parameter logic [15:0] REFRESH_BASE_TICKS = 16'(`CP_REFRESH_BASE_TICKS)
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       wr_valid_in,
  input  wire logic [4:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [4:0] pin_in,
  output logic            wr_ready_out,
  output logic      [4:0] pin_out,
  output logic      [4:0] pin_oe_out,
  output logic      [4:0] pin_level_out
);

  // ----------------------------------------------------------------
  // led mapping
  // ----------------------------------------------------------------
  // group g is the anode pin; slot s picks one of the other four pins
  function automatic logic [4:0] led_index(input logic [2:0] g, input logic [1:0] s);
    led_index = {g[2:0], s};
  endfunction

  function automatic logic [2:0] cathode_pin(input logic [2:0] g, input logic [1:0] s);
    cathode_pin = ({1'b0, s} < g) ? {1'b0, s} : 3'({1'b0, s} + 3'h1);
  endfunction

  charlieplex_pkg::scan_state_t state_q;
  logic [2:0]                   grp_q;
  logic [7:0]                   step_q;
  charlieplex_pkg::on_time_t    on_time_q [`CP_NUM_LEDS];
  logic [4:0]                   pin_meta_q;
  logic [4:0]                   drive_d;
  logic [4:0]                   oe_d;
  logic                         base_tick;
  logic                         refresh_tick;
  logic                         step_tick;
  logic                         scan_last;
  logic                         frame_start;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  event_timer #(.WIDTH(16)) base_clock_timer (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .clear_in    (1'b0),
    .count_en_in (1'b1),
    .period_in   (16'(`CP_BASE_DIV)),
    .tick_out    (base_tick)
  );

  // counts base ticks only, so the refresh rate follows the base timer
  event_timer #(.WIDTH(16)) refresh_tick_timer ( // R7
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .clear_in    (1'b0),
    .count_en_in (base_tick),
    .period_in   (REFRESH_BASE_TICKS), // R5 R6
    .tick_out    (refresh_tick)
  );

  // step pacing restarts only when a frame starts: a tick ignored mid-frame
  // must not stretch the step that is running
  event_timer #(.WIDTH(16)) step_timer (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .clear_in    (frame_start),
    .count_en_in (base_tick),
    .period_in   (16'(`CP_STEP_DIV)),
    .tick_out    (step_tick)
  );

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  assign scan_last = (state_q == charlieplex_pkg::ST_LIT) && step_tick && (step_q == `CP_LAST_STEP)
                     && (grp_q == `CP_LAST_GROUP);
  assign frame_start = (state_q == charlieplex_pkg::ST_IDLE) && refresh_tick;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_q <= charlieplex_pkg::ST_IDLE;
      grp_q   <= 3'h0;
      step_q  <= 8'h00;
    end
    else
    begin
      case (state_q)
        charlieplex_pkg::ST_IDLE:
        begin
          if (refresh_tick)
          begin
            state_q <= charlieplex_pkg::ST_BLANK; // R12
            grp_q   <= 3'h0;
            step_q  <= 8'h00;
          end
        end
        charlieplex_pkg::ST_BLANK:
        begin
          if (step_tick)
          begin
            if (step_q == 8'(`CP_BLANK_STEPS - 1))
            begin
              state_q <= charlieplex_pkg::ST_LIT;
              step_q  <= 8'h00;
            end
            else
              step_q <= step_q + 8'h01;
          end
        end
        charlieplex_pkg::ST_LIT:
        begin
          if (step_tick)
          begin
            step_q <= step_q + 8'h01;
            if (step_q == `CP_LAST_STEP)
            begin
              if (grp_q == `CP_LAST_GROUP)
                state_q <= charlieplex_pkg::ST_IDLE; // R12
              else
              begin
                grp_q   <= grp_q + 3'h1; // R4
                state_q <= charlieplex_pkg::ST_BLANK; // R14
              end
            end
          end
        end
        default:
          state_q <= charlieplex_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    drive_d = '0;
    oe_d    = '0; // R2 R14
    if (state_q == charlieplex_pkg::ST_LIT)
    begin
      drive_d[grp_q] = 1'b1; // R3
      oe_d[grp_q]    = 1'b1;
      for (int s = 0; s < `CP_SLOTS; s++)
      begin
        // index 19 (last slot of last group) has no led
        if (led_index(grp_q, 2'(s)) < 5'(`CP_NUM_LEDS))
        begin
          if (step_q < on_time_q[led_index(grp_q, 2'(s))]) // R11
            oe_d[cathode_pin(grp_q, 2'(s))] = 1'b1; // R1
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pin_out    <= 5'h00;
      pin_oe_out <= 5'h00;
    end
    else
    begin
      pin_out    <= drive_d;
      pin_oe_out <= oe_d;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      pin_meta_q    <= 5'h00;
      pin_level_out <= 5'h00;
    end
    else
    begin
      pin_meta_q    <= pin_in;
      pin_level_out <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // on-time table and status update port
  // ----------------------------------------------------------------
  // updates wait while a frame is scanned so the refresh is never disturbed
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      wr_ready_out <= 1'b0;
    else
      wr_ready_out <= ((state_q == charlieplex_pkg::ST_IDLE) && !refresh_tick) || scan_last; // R8 R9
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < `CP_NUM_LEDS; i++)
        on_time_q[i] <= 8'h00;
    end
    else if (wr_valid_in && wr_ready_out && (wr_idx_in < 5'(`CP_NUM_LEDS)))
      on_time_q[wr_idx_in] <= wr_data_in; // R10 R13
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [22:0] gap_q;
  logic        seen_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      gap_q  <= 23'h000000;
      seen_q <= 1'b0;
    end
    else if (refresh_tick)
    begin
      gap_q  <= 23'h000000;
      seen_q <= 1'b1;
    end
    else
      gap_q <= gap_q + 23'h000001;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  one_anode_a: assert property ($countones(pin_out & pin_oe_out) <= 1) // R3
    else $error("more than one pin drives high");
  blank_hiz_a: assert property ((state_q == charlieplex_pkg::ST_BLANK) |=> (pin_oe_out == 5'h00)) // R14
    else $error("pins driven during blanking");
  idle_hiz_a: assert property ((state_q == charlieplex_pkg::ST_IDLE) |=> (pin_oe_out == 5'h00)) // R2
    else $error("pins driven while idle");
  zero_dark_a: assert property ((state_q == charlieplex_pkg::ST_LIT && grp_q == 3'h0 && on_time_q[1] == 8'h00)
                                |=> !pin_oe_out[2]) // R11
    else $error("led with zero on-time lit");
  tick_start_a: assert property ((state_q == charlieplex_pkg::ST_IDLE && refresh_tick)
                                 |=> (state_q == charlieplex_pkg::ST_BLANK && grp_q == 3'h0)) // R12
    else $error("refresh tick did not start a frame");
  group_step_a: assert property ((state_q == charlieplex_pkg::ST_LIT && step_tick && step_q == `CP_LAST_STEP
                                  && grp_q != `CP_LAST_GROUP)
                                 |=> (state_q == charlieplex_pkg::ST_BLANK && grp_q == $past(grp_q) + 3'h1)) // R4
    else $error("group did not advance");
  write_stall_a: assert property ((state_q == charlieplex_pkg::ST_BLANK) |=> !wr_ready_out) // R8
    else $error("update accepted during scan");
  write_store_a: assert property ((wr_valid_in && wr_ready_out && wr_idx_in < 5'(`CP_NUM_LEDS))
                                  |=> (on_time_q[$past(wr_idx_in)] == $past(wr_data_in))) // R10
    else $error("on-time byte not stored");
  base_clocked_a: assert property (refresh_tick |-> $past(base_tick)) // R7
    else $error("refresh tick without base tick");
  refresh_rate_a: assert property ((refresh_tick && seen_q)
                                   |-> (gap_q == 23'(REFRESH_BASE_TICKS * `CP_BASE_DIV - 1))) // R5
    else $error("refresh period wrong");
  no_flicker_a: assert property (gap_q < 23'(`CP_CLK_HZ / `CP_MIN_REFRESH_HZ)) // R6
    else $error("refresh slower than flicker limit");

  frame_start_c: cover property (state_q == charlieplex_pkg::ST_IDLE && refresh_tick);
  led_lit_c: cover property (state_q == charlieplex_pkg::ST_LIT && $countones(pin_oe_out) > 1);
  frame_end_c: cover property (scan_last);
  write_c: cover property (wr_valid_in && wr_ready_out);

endmodule

/* File: sim/led_array_model.sv */
// behavioural array of nineteen leds on five tri-state pins
`timescale 1ns/10ps
module led_array_model (
  input  wire logic        clk_sys_in,
  input  wire logic [4:0]  pin_out_in,
  input  wire logic [4:0]  pin_oe_in,
  output logic      [4:0]  pin_wire_out,
  output wire logic [18:0] lit_out
);
  logic [4:0] float_q = 5'h0A;
  // no pulls on these pins: a released pin toggles rather than keep a stale level
  always @(posedge clk_sys_in)
    float_q <= ~float_q;
  assign pin_wire_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & float_q);
  for (genvar i = 0; i < 19; i++)
  begin : g_led
    localparam int A = i / 4;
    localparam int C = (i % 4 < A) ? i % 4 : i % 4 + 1;
    assign lit_out[i] = pin_oe_in[A] & pin_out_in[A] & pin_oe_in[C] & ~pin_out_in[C];
  end
endmodule

/* File: sim/charlieplex_led_scanner_bench.sv */
// self-checking bench for the charlieplexed led scanner
`timescale 1ns/10ps
module charlieplex_led_scanner_bench;
  localparam logic [15:0] P    = 16'h0064;
  localparam int          STEP = 2560;
  logic        clk_sys_in, rst_in, wr_valid_in, wr_ready_out;
  logic [4:0]  wr_idx_in, pin_in, pin_out, pin_oe_out, pin_level_out;
  logic [7:0]  wr_data_in;
  logic [18:0] lit, acc;
  logic [7:0]  ot [4];
  int          mismatches, n_tests, t0, n;

  charlieplex_led_scanner #(.REFRESH_BASE_TICKS(P)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wr_valid_in(wr_valid_in), .wr_idx_in(wr_idx_in), .wr_data_in(wr_data_in), .pin_in(pin_in),
    .wr_ready_out(wr_ready_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_level_out(pin_level_out));
  led_array_model leds (.clk_sys_in(clk_sys_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .pin_wire_out(pin_in), .lit_out(lit));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    repeat (3) @(posedge clk_sys_in);
    chk({wr_ready_out, pin_oe_out, pin_out, pin_level_out}, 19'h0);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t0 = $time;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(wr_ready_out, 19'h1);
    $display("done reset");
  endtask

  // led 0 is rewritten, index 19 does not exist and is dropped
  task automatic test_load();
    logic [4:0] idx [6] = '{5'h00, 5'h00, 5'h01, 5'h02, 5'h03, 5'h13};
    logic [7:0] dat [6] = '{8'hFF, 8'h02, 8'h00, 8'h01, 8'h03, 8'hFF};
    ot = '{8'h02, 8'h00, 8'h01, 8'h03};
    @(posedge clk_sys_in);
    wr_valid_in <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      wr_idx_in <= idx[i];
      wr_data_in <= dat[i];
      @(posedge clk_sys_in);
      chk(wr_ready_out, 19'h1);
    end
    wr_valid_in <= 1'b0;
    $display("done load");
  endtask

  // a pending update must stall for the first 100 cycles of the frame
  task automatic test_tick();
    n = 0;
    while (wr_ready_out !== 1'b0 && n < 8000)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    n = ($time - t0) / 5;
    chk(n > P * 64 - 70 && n < P * 64 + 70, 19'h1);
    wr_valid_in <= 1'b1;
    wr_idx_in <= 5'h01;
    wr_data_in <= 8'h09;
    repeat (100)
    begin
      @(posedge clk_sys_in);
      chk(wr_ready_out, 19'h0);
    end
    $display("done tick");
  endtask

  task automatic test_blank();
    n = 100;
    acc = 19'h0;
    // sample before stepping so the first lit cycle is not counted as blank
    while (pin_oe_out === 5'h00 && n < 20000)
    begin
      acc = acc | lit;
      @(posedge clk_sys_in);
      n++;
    end
    chk(n > 4 * STEP - 3 && n < 4 * STEP + 3, 19'h1);
    chk(acc, 19'h0);
    $display("done blank");
  endtask

  task automatic test_lit();
    logic [18:0] exp;
    repeat (STEP / 2) @(posedge clk_sys_in);
    for (int k = 0; k < 4; k++)
    begin
      exp = 19'h0;
      for (int i = 0; i < 4; i++)
        exp[i] = k < ot[i];
      chk(lit, exp);
      chk(pin_out & pin_oe_out, 19'h01);
      chk(pin_level_out & pin_oe_out, pin_out & pin_oe_out);
      repeat (STEP) @(posedge clk_sys_in);
    end
    $display("done lit");
  endtask

  // ----------------------------------------
  // run
  // ----------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  initial
  begin
    #250000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    rst_in = 1'b1;
    wr_valid_in = 1'b0;
    wr_idx_in = 5'h00;
    wr_data_in = 8'h00;
    mismatches = 0;
    n_tests = 0;
    test_reset();
    test_load();
    test_tick();
    test_blank();
    test_lit();
    end_sim();
  end
endmodule
